// *** pci_target_termination_ctl.sv ***
/*
  PCI target termination controller: decides disconnect, retry and abort
  toward an external PCI master, logs local bus errors of posted writes.
  Assumes the PCI clock and request signals arrive as pins sampled by the
  local clock i_mclk, and that the local bus logic runs on i_mclk.
*/
// Behaviour
// RULE_01 - disconnect drives trdy and stop together; the fifo-full and prefetch-stall disconnects drive stop alone
// RULE_02 - io space burst disconnects after first phase
// RULE_03 - unposted burst disconnects after delayed write
// RULE_04 - single local read ends burst read
// RULE_05 - disconnect at 128 byte boundary
// RULE_06 - disconnect burst write when fifo fills
// RULE_07 - disconnect non-linear address bursts
// RULE_08 - prefetch read stalled eight clocks disconnects
// RULE_09 - retry drives stop without trdy
// RULE_10 - retry posted write lacking cacheline free entries
// RULE_11 - retry while delayed transaction outstanding
// RULE_12 - retry burst read until local read ends
// RULE_13 - retry writes while any read pending
// RULE_14 - abort drives stop with devsel dropped
// RULE_15 - retry until local cycle ends, ignore retry
// RULE_16 - normal becomes completion, error becomes abort
// RULE_17 - posted writes never report local errors
// RULE_18 - log address, code, data, size; set flag
// RULE_19 - freeze fifo, suspend channel until cleared
// RULE_20 - without logging drop errored posted write
// RULE_21 - interrupt only when enable set
// RULE_22 - interrupt routed by direction bit
// RULE_23 - software clears flag; log stays stable
`timescale 1ns/1ps
`include "pci_term_defines.svh"

module pci_target_termination_ctl
  import pci_term_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_pclk,
  input wire pci_req_t i_pci_req,
  input wire logic i_rd_avail,
  input wire logic [3:0] i_fifo_free,
  input wire logic i_slave_read_busy,
  input wire lb_result_t i_lb_result,
  input wire pw_err_t i_pw_err,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output term_t o_term,
  output logic o_lb_start,
  output logic o_lb_is_write,
  output logic o_fifo_freeze,
  output logic o_drop_posted,
  output logic o_irq_local,
  output logic o_irq_pci
);

  typedef struct packed {
    term_state_t state;
    term_t term;
    logic [4:0] pclk_s;
    pci_req_t req_s1;
    pci_req_t req_s2;
    pci_req_t req_s3;
    pci_req_t req;
    lb_result_t res;
    logic res_ok;
    logic pend_write;
    logic [3:0] stall_cnt;
    logic [6:0] ctl;
    logic flag;
    logic [3:0] tc;
    logic [1:0] size;
    logic [31:0] eaddr;
    logic [31:0] edata;
    logic lb_start;
    logic drop;
    logic freeze;
    logic irq_l;
    logic irq_p;
    logic wait_n;
    logic [31:0] rdata;
  } st_t;

  st_t s_q;
  st_t s_d;

  logic pe;
  logic posting;
  logic [3:0] cl_words;
  logic log_en;
  logic suspended;
  logic disc;
  logic acc;
  logic flag_clr;
  logic [31:0] rd_mux;

  always_comb begin
    s_d = s_q;
    // request pins pass four flops, the last loading only once the words before it agree; the clock pin four to the edge
    s_d.pclk_s = {s_q.pclk_s[3:0], i_pclk};
    s_d.req_s1 = i_pci_req;
    s_d.req_s2 = s_q.req_s1;
    s_d.req_s3 = s_q.req_s2;
    if (s_q.req_s2 == s_q.req_s3) begin
      s_d.req = s_q.req_s3;
    end
    pe = s_q.pclk_s[3] & ~s_q.pclk_s[4];

    posting = s_q.ctl[`CTL_POSTED_WRITE_ENABLE];
    log_en = s_q.ctl[`CTL_ERROR_LOG_ENABLE];
    cl_words = (s_q.ctl[`CTL_CACHELINE_HI:`CTL_CACHELINE_LO] ==
                `CLINE_LONG_CODE) ? `CLINE_WORDS_LONG : `CLINE_WORDS_SHORT;
    suspended = s_q.flag & log_en;

    s_d.lb_start = 1'b0;
    s_d.drop = 1'b0;

    // local bus result of the outstanding delayed transaction
    if (s_q.state == ST_WAIT_LB && !s_q.res_ok && i_lb_result.done) begin
      if (i_lb_result.retry) begin
        s_d.lb_start = 1'b1; // [RULE_15]
      end else begin
        s_d.res = i_lb_result;
        s_d.res_ok = 1'b1;
      end
    end

    disc = s_q.req.io_space | s_q.req.nonlinear | // [RULE_02] [RULE_07]
           (s_q.req.addr_word == `BOUNDARY_LAST_WORD); // [RULE_05]

    if (pe) begin
      unique case (s_q.state)
        ST_IDLE: begin
          s_d.term = '0;
          s_d.stall_cnt = '0;
          if (s_q.req.start) begin
            if (suspended) begin
              s_d.term.stop = 1'b1; // [RULE_19]
            end else if (s_q.req.is_write && i_slave_read_busy) begin
              s_d.term.stop = 1'b1; // [RULE_13] [RULE_09]
            end else if (s_q.req.is_write && posting) begin
              if (i_fifo_free < cl_words) begin
                s_d.term.stop = 1'b1; // [RULE_10]
              end else begin
                // posted data never waits on the local outcome
                s_d.term.trdy = 1'b1; // [RULE_17]
                if (disc) begin
                  s_d.term.stop = 1'b1; // [RULE_01]
                end else if (s_q.req.burst && !s_q.req.last) begin
                  s_d.state = ST_XFER;
                end
              end
            end else begin
              // read or delayed write goes to the local bus first
              s_d.term.stop = 1'b1; // [RULE_15] [RULE_09]
              s_d.lb_start = 1'b1; // [RULE_15]
              s_d.pend_write = s_q.req.is_write;
              s_d.res_ok = 1'b0;
              s_d.state = ST_WAIT_LB;
            end
          end
        end
        ST_WAIT_LB: begin
          s_d.term = '0;
          if (s_q.req.start) begin
            if (!s_q.res_ok) begin
              s_d.term.stop = 1'b1; // [RULE_11] [RULE_12] [RULE_13]
            end else if (s_q.res.err) begin
              s_d.term.stop = 1'b1; // [RULE_16]
              s_d.term.devsel_off = 1'b1; // [RULE_14]
              s_d.state = ST_IDLE;
            end else begin
              s_d.term.trdy = 1'b1; // [RULE_16]
              s_d.state = ST_IDLE;
              if (s_q.req.burst && !s_q.req.last) begin
                if (!s_q.pend_write && s_q.res.multi && !disc) begin
                  s_d.state = ST_XFER;
                end else begin
                  s_d.term.stop = 1'b1; // [RULE_01] [RULE_03] [RULE_04]
                end
              end
            end
          end
        end
        ST_XFER: begin
          s_d.term = '0;
          if (s_q.req.is_write) begin
            if (i_fifo_free == 4'h0) begin
              s_d.term.stop = 1'b1; // [RULE_06]
              s_d.state = ST_IDLE;
            end else begin
              s_d.term.trdy = 1'b1;
              if (disc || i_fifo_free == 4'h1 || s_q.req.last) begin
                s_d.term.stop = ~s_q.req.last; // [RULE_06] [RULE_01]
                s_d.state = ST_IDLE;
              end
            end
          end else if (!i_rd_avail) begin
            s_d.stall_cnt = s_q.stall_cnt + 4'h1;
            if (s_q.ctl[`CTL_PREFETCH_DISCONNECT] &&
                s_q.stall_cnt == `PREFETCH_STALL_LAST) begin
              s_d.term.stop = 1'b1; // [RULE_08]
              s_d.state = ST_IDLE;
            end
          end else begin
            s_d.stall_cnt = '0;
            s_d.term.trdy = 1'b1;
            if (disc || s_q.req.last) begin
              s_d.term.stop = ~s_q.req.last; // [RULE_05] [RULE_01]
              s_d.state = ST_IDLE;
            end
          end
        end
        default: begin
          s_d.state = ST_IDLE;
          s_d.term = '0;
        end
      endcase
    end

    // avalon slave: one wait cycle, then the access completes
    // read data is latched when taken so it stands while waitrequest is low
    acc = (i_avs_read | i_avs_write) & s_q.wait_n;
    s_d.wait_n = ~acc;
    rd_mux = 32'h0;
    unique case (i_avs_address)
      `OFS_MISC_CONTROL_TWO: rd_mux = {25'h0, s_q.ctl};
      `OFS_LOCAL_ERROR_CTL_STATUS: begin
        rd_mux = {22'h0, s_q.size, s_q.tc, 3'h0, s_q.flag};
      end
      `OFS_LOCAL_ERROR_ADDRESS: rd_mux = s_q.eaddr;
      `OFS_LOCAL_ERROR_DATA: rd_mux = s_q.edata;
      `OFS_TERM_STATUS: begin
        rd_mux = {28'h0, (s_q.state == ST_WAIT_LB), suspended, s_q.state};
      end
      default: rd_mux = 32'h0;
    endcase
    if (i_avs_read && acc) begin
      s_d.rdata = rd_mux;
    end
    flag_clr = 1'b0;
    if (i_avs_write && !s_q.wait_n && i_avs_byteenable[0]) begin
      if (i_avs_address == `OFS_MISC_CONTROL_TWO) begin
        s_d.ctl = i_avs_writedata[6:0];
      end
      if (i_avs_address == `OFS_LOCAL_ERROR_CTL_STATUS) begin
        flag_clr = i_avs_writedata[`ERRCS_FLAG]; // [RULE_23]
      end
    end

    // posted write errors: log and freeze, or drop and go on
    if (i_pw_err.valid) begin
      if (log_en) begin
        if (!s_q.flag) begin
          s_d.eaddr = i_pw_err.addr; // [RULE_18]
          s_d.edata = i_pw_err.data;
          s_d.tc = i_pw_err.tc;
          s_d.size = i_pw_err.size;
        end
      end else begin
        s_d.drop = 1'b1; // [RULE_20]
      end
    end
    // a new error beats a clear in the same cycle
    s_d.flag = (s_q.flag & ~flag_clr) | (i_pw_err.valid & log_en); // [RULE_18]
    s_d.freeze = s_d.flag & s_d.ctl[`CTL_ERROR_LOG_ENABLE]; // [RULE_19]

    s_d.irq_l = s_q.flag & s_q.ctl[`CTL_ERROR_LOG_IRQ_ENABLE] & // [RULE_21]
                ~s_q.ctl[`CTL_ERROR_LOG_IRQ_ROUTE]; // [RULE_22]
    s_d.irq_p = s_q.flag & s_q.ctl[`CTL_ERROR_LOG_IRQ_ENABLE] &
                s_q.ctl[`CTL_ERROR_LOG_IRQ_ROUTE]; // [RULE_22]
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.state <= ST_IDLE;
      s_q.ctl <= `CTL_RESET;
      s_q.wait_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_avs_readdata = s_q.rdata;
  assign o_avs_waitrequest = s_q.wait_n;
  assign o_term = s_q.term;
  assign o_lb_start = s_q.lb_start;
  assign o_lb_is_write = s_q.pend_write;
  assign o_fifo_freeze = s_q.freeze; // [RULE_19]
  assign o_drop_posted = s_q.drop;
  assign o_irq_local = s_q.irq_l;
  assign o_irq_pci = s_q.irq_p;

endmodule

// *** pci_term_defines.svh ***
/*
  Offsets, field positions, reset values and counts of the PCI target
  termination controller. Assumes a byte-addressed Avalon-MM slave port.
*/
`ifndef PCI_TERM_DEFINES_SVH
`define PCI_TERM_DEFINES_SVH

`define OFS_MISC_CONTROL_TWO 5'h00
`define OFS_LOCAL_ERROR_CTL_STATUS 5'h04
`define OFS_LOCAL_ERROR_ADDRESS 5'h08
`define OFS_LOCAL_ERROR_DATA 5'h0C
`define OFS_TERM_STATUS 5'h10

`define CTL_POSTED_WRITE_ENABLE 0
`define CTL_CACHELINE_LO 1
`define CTL_CACHELINE_HI 2
`define CTL_PREFETCH_DISCONNECT 3
`define CTL_ERROR_LOG_ENABLE 4
`define CTL_ERROR_LOG_IRQ_ENABLE 5
`define CTL_ERROR_LOG_IRQ_ROUTE 6
`define CTL_RESET 7'h00

`define ERRCS_FLAG 0
`define ERRCS_TC_LO 4
`define ERRCS_TC_HI 7
`define ERRCS_SIZE_LO 8
`define ERRCS_SIZE_HI 9

`define CLINE_WORDS_SHORT 4'h4
`define CLINE_WORDS_LONG 4'h8
`define CLINE_LONG_CODE 2'h2
`define BOUNDARY_LAST_WORD 5'h1F
`define PREFETCH_STALL_LAST 4'h7

`endif

// *** pci_term_pkg.sv ***
/*
  Types of the PCI target termination controller: carriers for the
  sampled PCI request, the local bus result, the posted write error and
  the termination command. Assumes pci_term_defines.svh is unused here.
*/
package pci_term_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT_LB = 2'h1,
    ST_XFER = 2'h3,
    ST_SPARE = 2'h2
  } term_state_t;

  typedef struct packed {
    logic start;
    logic is_write;
    logic burst;
    logic io_space;
    logic nonlinear;
    logic last;
    logic [4:0] addr_word;
  } pci_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic retry;
    logic multi;
  } lb_result_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] tc;
    logic [1:0] size;
  } pw_err_t;

  typedef struct packed {
    logic stop;
    logic trdy;
    logic devsel_off;
  } term_t;

endpackage

// *** pci_term_sva.sv ***
/* Port checker of the termination controller, bound to every instance.
   Assumes one clock domain, i_mclk, with synchronous reset i_rst. */
`timescale 1ns/1ps
module pci_term_sva
  import pci_term_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire term_t o_term,
  input wire pw_err_t i_pw_err,
  input wire logic o_lb_start,
  input wire logic o_lb_is_write,
  input wire logic o_fifo_freeze,
  input wire logic o_drop_posted,
  input wire logic o_irq_local,
  input wire logic o_irq_pci
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_abort;
    o_term.devsel_off |-> o_term.stop && !o_term.trdy;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort without stop");
  property p_rd_retry;
    o_lb_start && !o_lb_is_write |-> ##[0:2] o_term.stop && !o_term.trdy;
  endproperty
  a_rd_retry: assert property (p_rd_retry)
    else $error("local read started without retry");
  property p_start_pulse;
    o_lb_start |=> !o_lb_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("local start longer than a pulse");
  property p_avs_answer;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_avs_answer: assert property (p_avs_answer)
    else $error("register access not answered");
  property p_avs_single;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_avs_single: assert property (p_avs_single)
    else $error("answer held too long");
  property p_irq_route;
    !(o_irq_local && o_irq_pci);
  endproperty
  a_irq_route: assert property (p_irq_route)
    else $error("interrupt on both buses");
  property p_drop;
    o_drop_posted |-> !o_fifo_freeze ##1 !o_drop_posted;
  endproperty
  a_drop: assert property (p_drop)
    else $error("drop while frozen or held");
  property p_freeze_cause;
    $rose(o_fifo_freeze) |-> $past(i_pw_err.valid) || $past(i_avs_write)
      || $past(i_avs_write, 2);
  endproperty
  a_freeze_cause: assert property (p_freeze_cause)
    else $error("freeze without error");
  c_abort: cover property (o_term.devsel_off);
  c_freeze: cover property (o_fifo_freeze && o_irq_pci);
  c_drop: cover property (o_drop_posted);
endmodule

bind pci_target_termination_ctl pci_term_sva i_sva(.i_mclk, .i_rst,
  .i_avs_read, .i_avs_write, .o_avs_waitrequest, .o_term, .i_pw_err,
  .o_lb_start, .o_lb_is_write, .o_fifo_freeze, .o_drop_posted,
  .o_irq_local, .o_irq_pci);

// *** pci_master_model.sv ***
/* PCI master model: makes the free-running PCI clock and runs one
   transaction per call. Assumes the target answers each PCI clock. */
`timescale 1ns/1ps
module pci_master_model
  import pci_term_pkg::*;
(
  input wire term_t i_term,
  output logic o_pclk,
  output pci_req_t o_req
);
  initial begin
    o_pclk = 1'b0;
    o_req = '0;
    #3;
    forever #40 o_pclk = ~o_pclk;
  end
  task automatic xfer(input logic [3:0] k, input logic [4:0] a,
      input int n, output int trdys, output term_t lt);
    trdys = 0;
    lt = '0;
    @(posedge o_pclk);
    o_req <= '{1'b1, k[3], k[2], k[1], k[0], n == 1, a};
    for (int p = 0; p < 12; p++) begin
      @(posedge o_pclk);
      lt = i_term;
      if (lt.trdy) trdys++;
      if (lt.stop && (lt.trdy || lt.devsel_off || trdys > 0)) break;
      if (trdys == n || p == 11) break;
      // retried: present a fresh address phase
      o_req <= '{lt.stop, k[3], k[2], k[1], k[0], trdys == n - 1,
        a + 5'(trdys)};
    end
    o_req <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ~o_req.addr_word};
  endtask
endmodule

// *** pci_target_termination_ctl_test.sv ***
/* Bench of the termination controller: a table of PCI transfers, then
   reset and error log cases. Assumes the master model and checker. */
`timescale 1ns/1ps
`include "pci_term_defines.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value at %0t: %h %h", $time, a, e); end end
module pci_target_termination_ctl_test
  import pci_term_pkg::*;
;
  typedef struct packed {
    logic [6:0] ctl;
    logic [3:0] kind;
    logic [4:0] a;
    logic [3:0] n, free;
    logic [2:0] env;
    logic [3:0] etr;
    logic [2:0] et;
  } row_t;
  row_t rows[9] = '{'{7'h01, 4'hC, 5'h1C, 4'h8, 4'h8, 3'h0, 4'h4, 3'h6},
    '{7'h01, 4'h6, 5'h00, 4'h4, 4'h8, 3'h1, 4'h1, 3'h6},
    '{7'h01, 4'h4, 5'h00, 4'h4, 4'h8, 3'h0, 4'h1, 3'h6},
    '{7'h00, 4'hC, 5'h00, 4'h4, 4'h2, 3'h0, 4'h1, 3'h6},
    '{7'h01, 4'hD, 5'h00, 4'h4, 4'h8, 3'h0, 4'h1, 3'h6},
    '{7'h01, 4'h0, 5'h00, 4'h1, 4'h8, 3'h2, 4'h0, 3'h5},
    '{7'h01, 4'h8, 5'h00, 4'h1, 4'h2, 3'h0, 4'h0, 3'h4},
    '{7'h05, 4'h8, 5'h00, 4'h1, 4'h5, 3'h0, 4'h0, 3'h4},
    '{7'h01, 4'h8, 5'h00, 4'h1, 4'h8, 3'h4, 4'h0, 3'h4}};
  logic [9:0] irq_rows[3] = '{{7'h71, 3'h6}, {7'h31, 3'h5}, {7'h11, 3'h4}};
  logic i_mclk = 1'b0, i_rst = 1'b1, i_rd_avail = 1'b1;
  logic i_slave_read_busy = 1'b0, lerr = 1'b0, lmul = 1'b0;
  logic i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [3:0] i_fifo_free = 4'h8, i_avs_byteenable = 4'hF, lbsh = 4'h0;
  logic [4:0] i_avs_address = 5'h00;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
  lb_result_t i_lb_result = '0;
  pw_err_t i_pw_err = '0;
  wire logic i_pclk;
  pci_req_t i_pci_req;
  term_t o_term, lt;
  logic o_avs_waitrequest, o_lb_start, o_lb_is_write, o_fifo_freeze;
  logic o_drop_posted, o_irq_local, o_irq_pci;
  int err_total = 0, compares = 0, drops = 0, nd, trd;
  pci_target_termination_ctl i_dut(.i_mclk, .i_rst, .i_pclk, .i_pci_req,
    .i_rd_avail, .i_fifo_free, .i_slave_read_busy, .i_lb_result, .i_pw_err,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_term,
    .o_lb_start, .o_lb_is_write, .o_fifo_freeze, .o_drop_posted,
    .o_irq_local, .o_irq_pci);
  pci_master_model i_pm(.i_term(o_term), .o_pclk(i_pclk), .o_req(i_pci_req));
  always #5 i_mclk = ~i_mclk;
  // local bus answers every started cycle five clocks later
  always @(posedge i_mclk) begin
    lbsh <= {lbsh[2:0], o_lb_start};
    i_lb_result <= '{lbsh[3], lerr & lbsh[3], 1'b0, lmul & lbsh[3]};
    if (o_drop_posted === 1'b1) drops <= drops + 1;
  end
  task automatic results;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d);
    int k;
    @(posedge i_mclk);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge i_mclk);
      if (o_avs_waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      err_total++;
      results();
    end
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic pulse(input logic [31:0] a, d);
    @(posedge i_mclk);
    i_pw_err <= '{1'b1, a, d, 4'h9, 2'h2};
    @(posedge i_mclk);
    i_pw_err.valid <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask
  initial begin
    repeat (16) @(posedge i_mclk);
    `CHK(o_avs_waitrequest, 1'b1);
    i_rst <= 1'b0;
    foreach (rows[i]) begin
      bus(1'b1, `OFS_MISC_CONTROL_TWO, {25'h0, rows[i].ctl});
      i_fifo_free <= rows[i].free;
      {i_slave_read_busy, lerr, lmul} <= rows[i].env;
      i_pm.xfer(rows[i].kind, rows[i].a, int'(rows[i].n), trd, lt);
      `CHK(trd[3:0], rows[i].etr);
      `CHK(lt, rows[i].et);
      `CHK(lt.devsel_off, rows[i].et[0]);
      $display("transfer row %0d done", i);
    end
    bus(1'b1, `OFS_MISC_CONTROL_TWO, 32'h9);
    i_rd_avail <= 1'b0;
    {i_slave_read_busy, lerr, lmul} <= 3'h1;
    i_pm.xfer(4'h4, 5'h00, 8, trd, lt);
    `CHK(trd, 1);
    `CHK(lt, 3'h4);
    $display("prefetch stall test done");
    @(posedge i_mclk);
    i_rd_avail <= 1'b1;
    i_rst <= 1'b1;
    repeat (4) @(posedge i_mclk);
    `CHK({o_avs_waitrequest, o_term}, 4'h8);
    i_rst <= 1'b0;
    bus(1'b0, `OFS_MISC_CONTROL_TWO, 32'h0);
    `CHK(q, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    `CHK(q, 32'h0);
    $display("reset test done");
    foreach (irq_rows[j]) begin
      bus(1'b1, `OFS_MISC_CONTROL_TWO, {25'h0, irq_rows[j][9:3]});
      pulse(32'hA5A5_0010, 32'h1234_5678);
      `CHK({o_fifo_freeze, o_irq_pci, o_irq_local}, irq_rows[j][2:0]);
      if (j == 0) begin
        bus(1'b0, `OFS_LOCAL_ERROR_CTL_STATUS, 32'h0);
        `CHK(q, 32'h0000_0291);
        pulse(32'h0BAD_0000, 32'h0);
        bus(1'b0, `OFS_LOCAL_ERROR_ADDRESS, 32'h0);
        `CHK(q, 32'hA5A5_0010);
        bus(1'b0, `OFS_LOCAL_ERROR_DATA, 32'h0);
        `CHK(q, 32'h1234_5678);
      end
      bus(1'b1, `OFS_LOCAL_ERROR_CTL_STATUS, 32'h1);
      repeat (2) @(posedge i_mclk);
      `CHK({o_fifo_freeze, o_irq_pci, o_irq_local}, 3'h0);
    end
    bus(1'b1, `OFS_MISC_CONTROL_TWO, 32'h1);
    nd = drops;
    pulse(32'h1, 32'h2);
    `CHK(drops - nd, 1);
    `CHK(o_fifo_freeze, 1'b0);
    $display("error log test done");
    results();
  end
endmodule
